// file: pcsi_pkg.sv
// Purpose: constants and types for the pc, stack and indirect block
// Assumes: one core instruction clock, decoder drives one command a cycle
// Notes:   all addresses are word or byte indices as named
package pcsi_pkg;
    // --------
    // widths and stack geometry
    // --------
    localparam int          PC_W       = 15;
    localparam int          STK_DEPTH  = 16;
    localparam int          SP_W       = 5;
    localparam logic [4:0]  SP_RESET   = 5'h1f;   // empty stack
    localparam logic [4:0]  SP_TOP     = 5'h0f;   // sixteenth level
    localparam logic [14:0] PC_RESET   = 15'h0000;
    localparam logic [14:0] INT_VECTOR = 15'h0004; // plain default
    // --------
    // pointer address map
    // --------
    localparam logic [15:0] TRAD_LAST  = 16'h0fff;
    localparam logic [15:0] LIN_FIRST  = 16'h2000;
    localparam logic [15:0] LIN_LAST   = 16'h29af;
    localparam int          FLASH_BIT  = 15;
    localparam logic [6:0]  IND_PORT0  = 7'h00;   // bank offset of port 0
    localparam logic [6:0]  IND_PORT1  = 7'h01;   // bank offset of port 1
    localparam logic [11:0] LIN_BLOCK  = 12'h050; // 80 bytes a bank
    localparam logic [6:0]  GPR_BASE   = 7'h20;   // gpr start in a bank
    // --------
    // decoder commands and access phases
    // --------
    typedef enum logic [3:0] {
        CMD_NONE  = 4'b0000,
        CMD_INC   = 4'b0001,
        CMD_PCL   = 4'b0010,
        CMD_CALL  = 4'b0011,
        CMD_CALL_VIA_ACCUMULATOR = 4'b0100,
        CMD_BRW   = 4'b0101,
        CMD_BRA   = 4'b0110,
        CMD_RET   = 4'b0111,
        CMD_INT   = 4'b1000
    } pcsi_cmd_e;
    typedef enum logic [1:0] {
        PH_IDLE   = 2'b00,
        PH_ACCESS = 2'b01,
        PH_EXTRA  = 2'b10
    } pcsi_phase_e;
endpackage : pcsi_pkg

// file: pcsi_core.sv
// Purpose: program counter loading, return stack, indirect addressing
// Assumes: decoder issues commands; data memory answers in its strobe cycle, flash one cycle after strobe
// Notes:   pc_out holds the already incremented fetch address
//
// Function
// RULE_01: computed jumps handle 256-word crossings themselves
// RULE_02: call loads operand, latch bits 6:3 on top
// RULE_03: call via accumulator loads accumulator and latch
// RULE_04: jump by accumulator adds unsigned accumulator
// RULE_05: signed branch adds sign-extended operand
// RULE_06: sixteen by fifteen stack outside memory spaces
// RULE_07: calls, interrupt push; returns pop; latch untouched
// RULE_08: disabled fault reset makes stack circular
// RULE_09: overflow and underflow flags always set
// RULE_10: five-bit pointer and top-of-stack pair accessible
// RULE_11: push increments then writes; pop reads then decrements
// RULE_12: enabled fault reset resets device, sets flag
// RULE_13: software minds pointer rewrites during interrupts
// RULE_14: port addressing itself reads zero, write dropped
// RULE_15: sixteen-bit pointer from high and low bytes
// RULE_16: 0x000-0xfff map to absolute data addresses
// RULE_17: linear region chains 80-byte gpr blocks
// RULE_18: unimplemented locations read zero
// RULE_19: top bit selects flash, low byte returned
// RULE_20: flash ignores writes through the pointer
// RULE_21: flash access costs one extra cycle
// RULE_22: every reset clears the program counter
// RULE_23: low byte write loads latch into upper bits
`timescale 1ns/1ps
module pcsi_core
    import pcsi_pkg::*;
(
    // clock, reset, enable
    input  wire logic        clock_in,
    input  wire logic        srst_in,
    input  wire logic        ce_in,
    // decoder command
    input  wire pcsi_cmd_e   cmd_in,
    input  wire logic [10:0] operand_in,
    input  wire logic [7:0]  byte_in,
    input  wire logic [6:0]  pc_high_latch_in,
    input  wire logic        stack_fault_reset_enable_in,
    // stack software access
    input  wire logic        sp_wr_in,
    input  wire logic [4:0]  sp_wdata_in,
    input  wire logic        tos_low_wr_in,
    input  wire logic        tos_high_wr_in,
    input  wire logic [7:0]  tos_wdata_in,
    input  wire logic        ovf_clr_in,
    input  wire logic        unf_clr_in,
    // indirect request
    input  wire logic        ind_rd_in,
    input  wire logic        ind_wr_in,
    input  wire logic [7:0]  file_select_high_in,
    input  wire logic [7:0]  file_select_low_in,
    input  wire logic [7:0]  ind_wdata_in,
    input  wire logic [7:0]  data_rdata_in,
    input  wire logic [13:0] flash_rdata_in,
    // program counter and stack state
    output logic      [14:0] pc_out,
    output logic      [4:0]  stack_pointer_reg_out,
    output logic      [14:0] stack_top_out,
    output logic             stack_overflow_flag_out,
    output logic             stack_underflow_flag_out,
    output logic             fault_reset_out,
    // indirect answer and memory strobes
    output logic             ind_ready_out,
    output logic             ind_done_out,
    output logic      [7:0]  ind_rdata_out,
    output logic      [11:0] data_addr_out,
    output logic             data_rd_out,
    output logic             data_wr_out,
    output logic      [7:0]  data_wdata_out,
    output logic      [14:0] flash_addr_out,
    output logic             flash_rd_out
);
    // --------
    // state
    // --------
    typedef struct packed {
        logic [14:0]        pc;
        logic [4:0]         sp;
        logic [15:0][14:0]  stk;
        logic               ovf;
        logic               unf;
        logic               fault;
        pcsi_phase_e        ph;
        logic               zero;
        logic               flash;
        logic [11:0]        daddr;
        logic               drd;
        logic               dwr;
        logic [7:0]         wdata;
        logic [14:0]        faddr;
        logic               frd;
        logic [7:0]         rdata;
        logic               done;
    } pcsi_state_s;

    pcsi_state_s r_reg;
    pcsi_state_s r_next;
    logic        push;
    logic        pop;
    logic        ovf_ev;
    logic        unf_ev;
    logic        do_fault;
    logic [4:0]  sp_inc;
    logic [14:0] pc_new;
    logic [15:0] file_select_pointer;
    logic [15:0][14:0] stk_upd;

    // --------
    // stack control and pc target
    // --------
    assign file_select_pointer      = {file_select_high_in, file_select_low_in}; // see RULE_15
    assign push     = (cmd_in == CMD_CALL) || (cmd_in == CMD_CALL_VIA_ACCUMULATOR)
                   || (cmd_in == CMD_INT);                       // see RULE_07
    assign pop      = (cmd_in == CMD_RET);                       // see RULE_07
    assign ovf_ev   = push && (r_reg.sp == SP_TOP);              // see RULE_09
    assign unf_ev   = pop && (r_reg.sp == SP_RESET);             // see RULE_09
    assign do_fault = stack_fault_reset_enable_in && (ovf_ev || unf_ev); // see RULE_12
    assign sp_inc   = r_reg.sp + 5'h01;                          // see RULE_11

    // next pc per command
    always_comb begin
        case (cmd_in)
            CMD_INC:   pc_new = r_reg.pc + 15'h0001;
            CMD_PCL:   pc_new = {pc_high_latch_in, byte_in};             // see RULE_23
            CMD_CALL:  pc_new = {pc_high_latch_in[6:3], operand_in};     // see RULE_02
            CMD_CALL_VIA_ACCUMULATOR: pc_new = {pc_high_latch_in, byte_in};             // see RULE_03
            CMD_BRW:   pc_new = r_reg.pc + {7'h00, byte_in};             // see RULE_04
            CMD_BRA:   pc_new = r_reg.pc + {{6{operand_in[8]}}, operand_in[8:0]}; // see RULE_05
            CMD_RET:   pc_new = r_reg.stk[r_reg.sp[3:0]];                // see RULE_11
            CMD_INT:   pc_new = INT_VECTOR;
            default:   pc_new = r_reg.pc;
        endcase
    end

    // per-entry write: push lands on the incremented index, wraps at 16
    genvar gi;
    generate
        for (gi = 0; gi < STK_DEPTH; gi++) begin : g_entry
            always_comb begin
                stk_upd[gi] = r_reg.stk[gi];
                if (push && !do_fault && (sp_inc[3:0] == 4'(gi))) begin
                    stk_upd[gi] = r_reg.pc; // see RULE_08
                end else if (r_reg.sp[3:0] == 4'(gi)) begin
                    if (tos_low_wr_in) begin
                        stk_upd[gi][7:0] = tos_wdata_in;         // see RULE_10
                    end
                    if (tos_high_wr_in) begin
                        stk_upd[gi][14:8] = tos_wdata_in[6:0];
                    end
                end
            end
        end
    endgenerate

    // --------
    // next state
    // --------
    always_comb begin
        r_next = r_reg;
        if (ce_in) begin
            // strobes and pulses last one enabled cycle
            {r_next.fault, r_next.drd, r_next.dwr, r_next.frd, r_next.done} = 5'h00;
            // program counter and stack
            r_next.stk = stk_upd;                                // see RULE_06
            if (cmd_in != CMD_NONE) begin
                r_next.pc = pc_new;
            end
            if (push) begin
                r_next.sp = sp_inc;                              // see RULE_11
            end else if (pop) begin
                r_next.sp = r_reg.sp - 5'h01;
            end else if (sp_wr_in) begin
                r_next.sp = sp_wdata_in;                         // see RULE_10
            end
            // flags: set wins over software clear
            r_next.ovf = ovf_ev || (r_reg.ovf && !ovf_clr_in); // see RULE_09
            r_next.unf = unf_ev || (r_reg.unf && !unf_clr_in);
            if (do_fault) begin
                r_next.fault = 1'b1;                             // see RULE_12
                r_next.pc    = PC_RESET;                         // see RULE_22
                r_next.sp    = SP_RESET;
            end
            // indirect access sequencer
            case (r_reg.ph)
                PH_IDLE: begin
                    if (ind_rd_in || ind_wr_in) begin
                        r_next.ph    = PH_ACCESS;
                        r_next.wdata = ind_wdata_in;
                        r_next.zero  = 1'b1;                     // see RULE_18
                        r_next.flash = 1'b0;
                        if (file_select_pointer[FLASH_BIT]) begin
                            r_next.flash = 1'b1;                 // see RULE_19
                            r_next.zero  = 1'b0;
                            r_next.faddr = file_select_pointer[14:0];
                            r_next.frd   = ind_rd_in;            // see RULE_20
                        end else if (file_select_pointer <= TRAD_LAST) begin
                            r_next.daddr = file_select_pointer[11:0];            // see RULE_16
                            if ((file_select_pointer[6:0] != IND_PORT0)
                                && (file_select_pointer[6:0] != IND_PORT1)) begin
                                r_next.zero = 1'b0;              // see RULE_14
                                r_next.drd  = ind_rd_in;
                                r_next.dwr  = ind_wr_in;
                            end
                        end else if ((file_select_pointer >= LIN_FIRST) && (file_select_pointer <= LIN_LAST)) begin
                            r_next.daddr = lin_map(file_select_pointer[11:0]);   // see RULE_17
                            r_next.zero  = 1'b0;
                            r_next.drd   = ind_rd_in;
                            r_next.dwr   = ind_wr_in;
                        end
                    end
                end
                PH_ACCESS: begin
                    if (r_reg.flash) begin
                        r_next.ph = PH_EXTRA;                    // see RULE_21
                    end else begin
                        r_next.ph    = PH_IDLE;
                        r_next.done  = 1'b1;
                        r_next.rdata = r_reg.zero ? 8'h00 : data_rdata_in; // see RULE_18
                    end
                end
                PH_EXTRA: begin
                    r_next.ph    = PH_IDLE;
                    r_next.done  = 1'b1;
                    r_next.rdata = flash_rdata_in[7:0];          // see RULE_19
                end
                default: r_next.ph = PH_IDLE;
            endcase
        end
    end

    // linear offset to bank and gpr byte
    function automatic logic [11:0] lin_map(input logic [11:0] off);
        logic [11:0] bank;
        logic [11:0] idx;
        bank    = off / LIN_BLOCK;
        idx     = off % LIN_BLOCK;
        lin_map = {bank[4:0], GPR_BASE + idx[6:0]};
    endfunction : lin_map

    // state register
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            r_reg       <= '0;
            r_reg.pc    <= PC_RESET;                             // see RULE_22
            r_reg.sp    <= SP_RESET;
            r_reg.ph    <= PH_IDLE;
        end else begin
            r_reg <= r_next;
        end
    end

    // --------
    // outputs
    // --------
    assign pc_out                   = r_reg.pc;
    assign stack_pointer_reg_out    = r_reg.sp;
    assign stack_top_out            = r_reg.stk[r_reg.sp[3:0]];  // see RULE_10
    assign stack_overflow_flag_out  = r_reg.ovf;
    assign stack_underflow_flag_out = r_reg.unf;
    assign fault_reset_out          = r_reg.fault;
    assign ind_ready_out            = (r_reg.ph == PH_IDLE);
    assign ind_done_out             = r_reg.done;
    assign ind_rdata_out            = r_reg.rdata;
    assign data_addr_out            = r_reg.daddr;
    assign data_rd_out              = r_reg.drd;
    assign data_wr_out              = r_reg.dwr;
    assign data_wdata_out           = r_reg.wdata;
    assign flash_addr_out           = r_reg.faddr;
    assign flash_rd_out             = r_reg.frd;

    // --------
    // assertions
    // --------
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (srst_in);

    property p_call;
        ce_in && cmd_in == CMD_CALL && !do_fault |=>
            pc_out == {$past(pc_high_latch_in[6:3]), $past(operand_in)};
    endproperty
    a_call: assert property (p_call) else $error("call target wrong"); // see RULE_02
    property p_call_via_accumulator;
        ce_in && cmd_in == CMD_CALL_VIA_ACCUMULATOR && !do_fault |=>
            pc_out == {$past(pc_high_latch_in), $past(byte_in)};
    endproperty
    a_call_via_accumulator: assert property (p_call_via_accumulator) else $error("call_via_accumulator target wrong"); // see RULE_03
    property p_brw;
        ce_in && cmd_in == CMD_BRW |=> pc_out == $past(pc_out) + {7'h00, $past(byte_in)};
    endproperty
    a_brw: assert property (p_brw) else $error("brw target wrong"); // see RULE_04
    property p_bra;
        ce_in && cmd_in == CMD_BRA |=>
            pc_out == $past(pc_out) + {{6{$past(operand_in[8])}}, $past(operand_in[8:0])};
    endproperty
    a_bra: assert property (p_bra) else $error("bra target wrong"); // see RULE_05
    property p_push_ret;
        ce_in && push && !do_fault ##1 ce_in && cmd_in == CMD_RET |=>
            pc_out == $past(pc_out, 2) && stack_pointer_reg_out == $past(stack_pointer_reg_out, 2);
    endproperty
    a_push_ret: assert property (p_push_ret) else $error("return lost address"); // see RULE_11
    property p_ovf;
        ce_in && ovf_ev |=> stack_overflow_flag_out && (fault_reset_out == $past(stack_fault_reset_enable_in));
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow not flagged"); // see RULE_09
    property p_fault;
        ce_in && do_fault |=> pc_out == PC_RESET && stack_pointer_reg_out == SP_RESET;
    endproperty
    a_fault: assert property (p_fault) else $error("fault reset missing"); // see RULE_12
    property p_port_self;
        ce_in && ind_ready_out && ind_rd_in && !file_select_pointer[15] && file_select_pointer[15:12] == 4'h0 && file_select_pointer[6:1] == 6'h00
            |=> !data_rd_out && !data_wr_out ##1 ind_done_out && ind_rdata_out == 8'h00;
    endproperty
    a_port_self: assert property (p_port_self) else $error("port self access"); // see RULE_14
    property p_flash_slow;
        ce_in && ind_ready_out && (ind_rd_in || ind_wr_in) && file_select_pointer[15] ##1 ce_in [*2]
            |-> !ind_done_out ##1 ind_done_out;
    endproperty
    a_flash_slow: assert property (p_flash_slow) else $error("flash timing wrong"); // see RULE_21
    property p_flash_nowr;
        ce_in && ind_ready_out && ind_wr_in && file_select_pointer[15] |=> !data_wr_out;
    endproperty
    a_flash_nowr: assert property (p_flash_nowr) else $error("flash written"); // see RULE_20

    c_wrap: cover property (ce_in && push && ovf_ev && !stack_fault_reset_enable_in);
    c_under: cover property (ce_in && unf_ev);
    c_lin: cover property (ce_in && ind_ready_out && ind_rd_in && file_select_pointer >= LIN_FIRST && file_select_pointer <= LIN_LAST);
    c_flash: cover property (ce_in && ind_ready_out && ind_rd_in && file_select_pointer[15]);
endmodule : pcsi_core

// file: pcsi_mem_model.sv
// Purpose: data memory and flash behind the block's memory strobes
// Assumes: a data read answers in its strobe cycle, flash one cycle later
// Notes:   an idle read line shows the inverse of its last value
`timescale 1ns/1ps
module pcsi_mem_model (
    // clock
    input  wire logic        clock_in,
    // data memory side
    input  wire logic [11:0] data_addr_in,
    input  wire logic        data_rd_in,
    input  wire logic        data_wr_in,
    input  wire logic [7:0]  data_wdata_in,
    output logic      [7:0]  data_rdata_out,
    // flash side
    input  wire logic [14:0] flash_addr_in,
    input  wire logic        flash_rd_in,
    output logic      [13:0] flash_rdata_out
);
    logic [7:0]  ram [4096];
    logic [7:0]  last_reg = 8'h00;
    logic [13:0] word_reg = 14'h0000;
    logic        fvalid_reg = 1'b0;
    // ram holds a pattern of its own address until written
    initial begin
        for (int i = 0; i < 4096; i++) ram[i] = i[7:0] ^ i[11:4];
    end
    // writes land, flash word appears the cycle after its strobe
    always @(posedge clock_in) begin
        if (data_wr_in) ram[data_addr_in] <= data_wdata_in;
        if (data_rd_in) last_reg <= ram[data_addr_in];
        fvalid_reg <= flash_rd_in;
        if (flash_rd_in) word_reg <= {flash_addr_in[13:8], flash_addr_in[7:0] ^ 8'h3c};
    end
    // released lines never keep a stale value
    assign data_rdata_out  = data_rd_in ? ram[data_addr_in] : ~last_reg;
    assign flash_rdata_out = fvalid_reg ? word_reg : ~word_reg;
endmodule : pcsi_mem_model

// file: test_pc_stack_indirect_addressing.sv
// Purpose: self-checking bench for pc loading, return stack and indirect access
// Assumes: inputs change and outputs are read at the falling edge
// Notes:   a mirror of pc and stack predicts every command
`timescale 1ns/1ps
module test_pc_stack_indirect_addressing import pcsi_pkg::*;;
    // --------
    // signals, design and memory model
    // --------
    logic        clock_in = 1'b0, srst_in = 1'b1, ce_in = 1'b1;
    pcsi_cmd_e   cmd_in = CMD_NONE;
    logic [10:0] operand_in = 11'h000;
    logic [7:0]  byte_in = 8'h00, tos_wdata_in = 8'h00, ind_wdata_in = 8'h00;
    logic [7:0]  file_select_high_in = 8'h00, file_select_low_in = 8'h00;
    logic [6:0]  pc_high_latch_in = 7'h00;
    logic [4:0]  sp_wdata_in = 5'h00, stack_pointer_reg_out;
    logic        stack_fault_reset_enable_in = 1'b0, sp_wr_in = 1'b0, tos_low_wr_in = 1'b0;
    logic        tos_high_wr_in = 1'b0, ovf_clr_in = 1'b0, unf_clr_in = 1'b0;
    logic        ind_rd_in = 1'b0, ind_wr_in = 1'b0;
    logic [7:0]  data_rdata_in, ind_rdata_out, data_wdata_out;
    logic [13:0] flash_rdata_in;
    logic [14:0] pc_out, stack_top_out, flash_addr_out;
    logic [11:0] data_addr_out;
    logic        stack_overflow_flag_out, stack_underflow_flag_out, fault_reset_out;
    logic        ind_ready_out, ind_done_out, data_rd_out, data_wr_out, flash_rd_out;
    logic [14:0] stk [16];
    logic [14:0] e_pc;
    logic [4:0]  e_sp;
    logic        e_ovf, e_unf, e_flt;
    logic [31:0] seed = 32'h656125f8;
    int          n_errors = 0, samples_checked = 0;

    pcsi_core dut_u (
        .clock_in, .srst_in, .ce_in, .cmd_in, .operand_in, .byte_in, .pc_high_latch_in,
        .stack_fault_reset_enable_in, .sp_wr_in, .sp_wdata_in, .tos_low_wr_in,
        .tos_high_wr_in, .tos_wdata_in, .ovf_clr_in, .unf_clr_in, .ind_rd_in, .ind_wr_in,
        .file_select_high_in, .file_select_low_in, .ind_wdata_in, .data_rdata_in,
        .flash_rdata_in, .pc_out, .stack_pointer_reg_out, .stack_top_out,
        .stack_overflow_flag_out, .stack_underflow_flag_out, .fault_reset_out,
        .ind_ready_out, .ind_done_out, .ind_rdata_out, .data_addr_out, .data_rd_out,
        .data_wr_out, .data_wdata_out, .flash_addr_out, .flash_rd_out
    );
    pcsi_mem_model mem_u (
        .clock_in, .data_addr_in(data_addr_out), .data_rd_in(data_rd_out),
        .data_wr_in(data_wr_out), .data_wdata_in(data_wdata_out),
        .data_rdata_out(data_rdata_in), .flash_addr_in(flash_addr_out),
        .flash_rd_in(flash_rd_out), .flash_rdata_out(flash_rdata_in)
    );
    // --------
    // helpers
    // --------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // byte that the memory model holds at a data address
    function automatic logic [7:0] mexp(input logic [11:0] a);
        return a[7:0] ^ a[11:4];
    endfunction : mexp
    // linear offset to data address: 80 bytes a bank after the sfr part
    function automatic logic [11:0] lin(input logic [15:0] k);
        return 12'((k / 16'h0050) * 16'h0080 + 16'h0020 + k % 16'h0050);
    endfunction : lin
    task automatic chk(input string what, input logic [14:0] exp, input logic [14:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wrap_up();
        $display("errors %0d, checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : wrap_up
    task automatic do_reset();
        cmd_in = CMD_NONE;
        srst_in = 1'b1;
        repeat (4) @(negedge clock_in);
        srst_in = 1'b0;
        e_pc = PC_RESET;
        e_sp = SP_RESET;
        e_ovf = 1'b0;
        e_unf = 1'b0;
        foreach (stk[i]) stk[i] = 15'h0000;
    endtask : do_reset
    // one decoder command, mirror updated, pc, sp, top of stack and flags compared
    task automatic do_cmd(input pcsi_cmd_e c, input logic [10:0] op, input logic [7:0] b);
        logic        push;
        logic [14:0] tgt;
        push = (c == CMD_CALL) || (c == CMD_CALL_VIA_ACCUMULATOR) || (c == CMD_INT);
        cmd_in = c;
        operand_in = op;
        byte_in = b;
        @(posedge clock_in);
        e_flt = 1'b0;
        case (c)
            CMD_CALL:           tgt = {pc_high_latch_in[6:3], op};
            CMD_CALL_VIA_ACCUMULATOR, CMD_PCL: tgt = {pc_high_latch_in, b};
            CMD_BRW:            tgt = e_pc + {7'h00, b};
            CMD_BRA:            tgt = e_pc + {{6{op[8]}}, op[8:0]};
            CMD_INT:            tgt = INT_VECTOR;
            CMD_INC:            tgt = e_pc + 15'h0001;
            CMD_RET:            tgt = stk[e_sp[3:0]];
            default:            tgt = e_pc;
        endcase
        if (!ce_in) tgt = e_pc;
        else if (push) begin
            e_ovf = e_ovf | (e_sp == SP_TOP);
            e_flt = stack_fault_reset_enable_in && (e_sp == SP_TOP);
            if (!e_flt) e_sp = e_sp + 5'h01;
            if (!e_flt) stk[e_sp[3:0]] = e_pc;
        end else if (c == CMD_RET) begin
            e_unf = e_unf | (e_sp == SP_RESET);
            e_flt = stack_fault_reset_enable_in && (e_sp == SP_RESET);
            if (!e_flt) e_sp = e_sp - 5'h01;
        end
        if (e_flt) e_sp = SP_RESET;
        e_pc = e_flt ? PC_RESET : tgt;
        @(negedge clock_in);
        chk("pc", e_pc, pc_out);
        chk("sp", {10'h000, e_sp}, {10'h000, stack_pointer_reg_out});
        chk("top", stk[e_sp[3:0]], stack_top_out);
        chk("flags", {12'h000, e_ovf, e_unf, e_flt},
            {12'h000, stack_overflow_flag_out, stack_underflow_flag_out, fault_reset_out});
    endtask : do_cmd
    // one-cycle pulse on sp write, tos writes and flag clears
    task automatic pulse(input logic [4:0] sel, input logic [7:0] d);
        cmd_in = CMD_NONE;
        {sp_wr_in, tos_low_wr_in, tos_high_wr_in, ovf_clr_in, unf_clr_in} = sel;
        sp_wdata_in = d[4:0];
        tos_wdata_in = d;
        @(negedge clock_in);
        {sp_wr_in, tos_low_wr_in, tos_high_wr_in, ovf_clr_in, unf_clr_in} = 5'h00;
        @(negedge clock_in);
    endtask : pulse
    // one indirect access; lat 0 leaves the latency unchecked
    task automatic ind(input logic wr, input logic [15:0] a, input logic [7:0] d,
                       input logic [7:0] er, input logic [3:0] lat, input logic ewr);
        logic [3:0] n;
        logic       saw;
        cmd_in = CMD_NONE;
        repeat (8) if (ind_ready_out !== 1'b1) @(negedge clock_in);
        {ind_rd_in, ind_wr_in} = {!wr, wr};
        {file_select_high_in, file_select_low_in} = a;
        ind_wdata_in = d;
        @(negedge clock_in);
        {ind_rd_in, ind_wr_in} = 2'h0;
        n = 4'h1;
        saw = (data_wr_out === 1'b1);
        do begin
            @(negedge clock_in);
            n = n + 4'h1;
            saw = saw | (data_wr_out === 1'b1);
        end while (ind_done_out !== 1'b1 && n < 4'h8);
        if (lat != 4'h0) chk("latency", {11'h000, lat}, {11'h000, n});
        if (!wr) chk("rdata", {7'h00, er}, {7'h00, ind_rdata_out});
        chk("data write", {14'h0000, ewr}, {14'h0000, saw});
    endtask : ind
    // --------
    // clock, watchdog and test sequence
    // --------
    initial begin
        forever #20 clock_in = ~clock_in;
    end
    // cut a hang short well past the expected run length
    initial begin
        #(40 * 4000);
        n_errors++;
        wrap_up();
    end
    initial begin : main_seq
        pcsi_cmd_e   ops [6];
        pcsi_cmd_e   c;
        logic [15:0] lk [4];
        ops = '{CMD_INC, CMD_CALL, CMD_CALL_VIA_ACCUMULATOR, CMD_BRW, CMD_BRA, CMD_RET};
        lk = '{16'h0000, 16'h004f, 16'h0050, 16'h09af};
        do_reset();
        do_cmd(CMD_NONE, 11'h000, 8'h00);
        pc_high_latch_in = 7'h5a;
        do_cmd(CMD_INC, 11'h000, 8'h00);
        do_cmd(CMD_CALL, 11'h7ff, 8'h00);
        do_cmd(CMD_CALL_VIA_ACCUMULATOR, 11'h000, 8'hfe);
        do_cmd(CMD_BRW, 11'h000, 8'hff);
        do_cmd(CMD_BRA, 11'h100, 8'h00);
        do_cmd(CMD_PCL, 11'h000, 8'h12);
        do_cmd(CMD_INT, 11'h000, 8'h00);
        repeat (3) do_cmd(CMD_RET, 11'h000, 8'h00);
        ce_in = 1'b0;
        do_cmd(CMD_INC, 11'h000, 8'h00);
        ce_in = 1'b1;
        // random commands and data reads away from the port offsets
        repeat (60) begin
            seed = lfsr(seed);
            c = ops[seed[31:29] % 3'h6];
            if ((c == CMD_CALL || c == CMD_CALL_VIA_ACCUMULATOR) && e_sp == SP_TOP) c = CMD_RET;
            if (c == CMD_RET && e_sp == SP_RESET) c = CMD_INC;
            pc_high_latch_in = seed[6:0];
            do_cmd(c, seed[20:10], seed[28:21]);
            ind(1'b0, {4'h0, seed[11:0] | 12'h002}, 8'h00,
                mexp(seed[11:0] | 12'h002), 4'h2, 1'b0);
        end
        pulse(5'h10, 8'h03);
        e_sp = 5'h03;
        pulse(5'h08, 8'h5a);
        pulse(5'h04, 8'h2b);
        stk[3] = {7'h2b, 8'h5a};
        chk("top", stk[3], stack_top_out);
        do_cmd(CMD_RET, 11'h000, 8'h00);
        // circular stack, then fault resets
        do_reset();
        repeat (18) begin
            seed = lfsr(seed);
            do_cmd(CMD_CALL, seed[10:0], 8'h00);
        end
        pulse(5'h02, 8'h00);
        e_ovf = 1'b0;
        chk("ovf", 15'h0000, {14'h0000, stack_overflow_flag_out});
        do_reset();
        stack_fault_reset_enable_in = 1'b1;
        repeat (17) do_cmd(CMD_CALL, 11'h2c4, 8'h00);
        do_cmd(CMD_RET, 11'h000, 8'h00);
        pulse(5'h01, 8'h00);
        e_unf = 1'b0;
        chk("unf", 15'h0000, {14'h0000, stack_underflow_flag_out});
        do_reset();
        stack_fault_reset_enable_in = 1'b0;
        do_cmd(CMD_RET, 11'h000, 8'h00);
        // indirect regions
        ind(1'b1, 16'h00b5, 8'hc3, 8'h00, 4'h2, 1'b1);
        ind(1'b0, 16'h00b5, 8'h00, 8'hc3, 4'h2, 1'b0);
        ind(1'b0, 16'h0080, 8'h00, 8'h00, 4'h2, 1'b0);
        ind(1'b1, 16'h0f81, 8'h77, 8'h00, 4'h2, 1'b0);
        foreach (lk[i]) ind(1'b0, 16'h2000 + lk[i], 8'h00, mexp(lin(lk[i])), 4'h2, 1'b0);
        ind(1'b0, 16'h1000, 8'h00, 8'h00, 4'h2, 1'b0);
        ind(1'b0, 16'h29b0, 8'h00, 8'h00, 4'h2, 1'b0);
        ind(1'b0, 16'hffff, 8'h00, 8'hc3, 4'h3, 1'b0);
        ind(1'b0, 16'h8155, 8'h00, 8'h69, 4'h3, 1'b0);
        ind(1'b1, 16'h8123, 8'h55, 8'h00, 4'h0, 1'b0);
        wrap_up();
    end
endmodule : test_pc_stack_indirect_addressing
